/* File: pkg/gpio_map_consts.vh */
`ifndef GPIO_MAP_CONSTS_VH
`define GPIO_MAP_CONSTS_VH

// Register offsets (byte addresses on the plain port)
`define ADDR_W 8
`define OFF_SETUP_BASE 8'h00
`define OFF_OUT_USER 8'h20
`define OFF_IN_STATE 8'h24
`define OFF_PIN_STATE 8'h28
`define OFF_IRQ_STATUS 8'h2C
`define OFF_IRQ_MASK 8'h30
`define OFF_FUNC_STATUS 8'h34

// Setup word fields, one word per point
`define SU_FUNC_LSB 0
`define SU_FUNC_MSB 3
`define SU_DIR_BIT 4
`define SU_POL_BIT 5
`define SU_SRC_BIT 6
`define SU_CFG_BIT 7
`define SU_W 8
`define SU_RESET 8'h00

// Input function codes
`define IF_USER 4'h0
`define IF_HOME 4'h1
`define IF_PLIM 4'h2
`define IF_NLIM 4'h3
`define IF_GO 4'h4
`define IF_STOP 4'h5
`define IF_PAUSE 4'h6
`define IF_JOGP 4'h7
`define IF_JOGN 4'h8
`define IF_RESET 4'h9

// Output function codes
`define OF_USER 4'h0
`define OF_MOVING 4'h1
`define OF_FAULT 4'h2
`define OF_STALL 4'h3
`define OF_VCHG 4'h4

// Interrupt status bits
`define IRQ_GO 0
`define IRQ_STOP 1
`define IRQ_PAUSE 2
`define IRQ_RESET 3
`define IRQ_W 4

// Program start address for the go function
`define PROG_START_ADDR 16'h0001

`endif

/* File: verilog/general_io_function_mapper.v */
// Function
// - Active high: high pin reads one
// - Active low: mapping inverted
// - Polarity bit per point setup word
// - Unconfigured point stays idle
// - Each point input/output, sink/source
// - User inputs readable, grouped as bank
// - Go input starts program at address one
// - Stop input decelerates, halts program
// - Pause input toggles suspend and resume
// - Reset input acts like control-C
// - User output set only by program
// - Moving output active while moving
// - Stall output active on stall, encoder
// - Velocity output active while ramping and moving
`timescale 1ns/1ps
`include "gpio_map_consts.vh"

module general_io_function_mapper #(
  parameter NPTS = 8
) (
  input wire sys_clk_i, // System clock, 50 MHz
  input wire nrst_i, // Asynchronous reset, active low
  input wire [`ADDR_W-1:0] addr_i, // Register byte address
  input wire [31:0] wdata_i, // Write data
  input wire wr_i, // Write strobe
  input wire rd_i, // Read strobe
  output reg [31:0] rdata_o, // Read data, cycle after strobe
  input wire [NPTS-1:0] pin_i, // Pin levels seen at the points
  output reg [NPTS-1:0] pin_o, // Pin drive level
  output reg [NPTS-1:0] pin_oe_o, // High while point drives pin
  output reg [NPTS-1:0] src_type_o, // Point is sourcing type
  input wire moving_i, // Motor in motion
  input wire fault_i, // Error condition detected
  input wire stall_i, // Stall detected
  input wire encoder_i, // Encoder fitted
  input wire ramping_i, // Accelerating or decelerating
  output reg home_o, // Homing reference
  output reg plim_o, // Positive travel inhibited
  output reg nlim_o, // Negative travel inhibited
  output reg jogp_o, // Jog positive while high
  output reg jogn_o, // Jog negative while high
  output reg prog_start_o, // Start program pulse
  output reg [15:0] prog_addr_o, // Start address
  output reg stop_decel_o, // Decelerating stop pulse
  output reg prog_halt_o, // Halt program pulse
  output reg paused_o, // Program and motion suspended
  output reg prog_reset_o, // Control-C style reset pulse
  output reg irq_o // Level interrupt
);

  reg [`SU_W-1:0] setup_r [0:NPTS-1];
  reg [NPTS-1:0] out_user_r;
  reg [NPTS-1:0] in_state_r;
  reg [NPTS-1:0] in_prev_r;
  reg [`IRQ_W-1:0] irq_stat_r;
  reg [`IRQ_W-1:0] irq_mask_r;
  reg [NPTS-1:0] logic_nxt;
  reg [NPTS-1:0] drive_nxt;
  reg [NPTS-1:0] oe_nxt;
  reg [NPTS-1:0] src_nxt;
  reg [NPTS-1:0] user_in_nxt;
  reg [4:0] fn_lvl_nxt;
  reg [`IRQ_W-1:0] ev_nxt;
  reg [31:0] rd_nxt;
  reg [3:0] fn;
  reg is_out;
  reg cfg;
  reg pol_low;
  reg rise;
  reg out_state;
  integer i;
  integer j;
  integer m;

  // Per point decode of polarity, direction and function
  always @* begin
    logic_nxt = {NPTS{1'b0}};
    drive_nxt = {NPTS{1'b0}};
    oe_nxt = {NPTS{1'b0}};
    src_nxt = {NPTS{1'b0}};
    user_in_nxt = {NPTS{1'b0}};
    fn_lvl_nxt = 5'h00;
    ev_nxt = {`IRQ_W{1'b0}};
    fn = 4'h0;
    is_out = 1'b0;
    cfg = 1'b0;
    pol_low = 1'b0;
    rise = 1'b0;
    out_state = 1'b0;
    for (i = 0; i < NPTS; i = i + 1) begin
      fn = setup_r[i][`SU_FUNC_MSB:`SU_FUNC_LSB];
      is_out = setup_r[i][`SU_DIR_BIT];
      cfg = setup_r[i][`SU_CFG_BIT];
      pol_low = setup_r[i][`SU_POL_BIT];
      src_nxt[i] = setup_r[i][`SU_SRC_BIT];
      // Logical state: pin level, inverted for active low
      logic_nxt[i] = pin_i[i] ^ pol_low;
      rise = in_state_r[i] & ~in_prev_r[i];
      if (cfg && !is_out) begin
        case (fn)
          `IF_USER: user_in_nxt[i] = in_state_r[i];
          `IF_HOME: fn_lvl_nxt[0] = fn_lvl_nxt[0] | in_state_r[i];
          `IF_PLIM: fn_lvl_nxt[1] = fn_lvl_nxt[1] | in_state_r[i];
          `IF_NLIM: fn_lvl_nxt[2] = fn_lvl_nxt[2] | in_state_r[i];
          `IF_JOGP: fn_lvl_nxt[3] = fn_lvl_nxt[3] | in_state_r[i];
          `IF_JOGN: fn_lvl_nxt[4] = fn_lvl_nxt[4] | in_state_r[i];
          `IF_GO: ev_nxt[`IRQ_GO] = ev_nxt[`IRQ_GO] | rise;
          `IF_STOP: ev_nxt[`IRQ_STOP] = ev_nxt[`IRQ_STOP] | rise;
          `IF_PAUSE: ev_nxt[`IRQ_PAUSE] = ev_nxt[`IRQ_PAUSE] | rise;
          `IF_RESET: ev_nxt[`IRQ_RESET] = ev_nxt[`IRQ_RESET] | rise;
          default: ;
        endcase
      end
      if (cfg && is_out) begin
        case (fn)
          `OF_USER: out_state = out_user_r[i];
          `OF_MOVING: out_state = moving_i;
          `OF_FAULT: out_state = fault_i;
          `OF_STALL: out_state = stall_i & encoder_i;
          `OF_VCHG: out_state = ramping_i & moving_i;
          default: out_state = 1'b0;
        endcase
        // Drive level follows polarity, same mapping as inputs
        drive_nxt[i] = out_state ^ pol_low;
        oe_nxt[i] = 1'b1;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rd_nxt = 32'h0000_0000;
    for (j = 0; j < NPTS; j = j + 1) begin
      if (addr_i == `OFF_SETUP_BASE + j * 4)
        rd_nxt = {24'h000000, setup_r[j]};
    end
    case (addr_i)
      `OFF_OUT_USER: rd_nxt = {24'h000000, out_user_r};
      `OFF_IN_STATE: rd_nxt = {24'h000000, user_in_nxt};
      `OFF_PIN_STATE: rd_nxt = {24'h000000, in_state_r};
      `OFF_IRQ_STATUS: rd_nxt = {28'h0000000, irq_stat_r};
      `OFF_IRQ_MASK: rd_nxt = {28'h0000000, irq_mask_r};
      `OFF_FUNC_STATUS: rd_nxt = {26'h0000000, paused_o, fn_lvl_nxt};
      default: ;
    endcase
  end

  // Setup words; points start unconfigured and idle
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (m = 0; m < NPTS; m = m + 1)
        setup_r[m] <= `SU_RESET;
    end else begin
      for (m = 0; m < NPTS; m = m + 1)
        if (wr_i && addr_i == `OFF_SETUP_BASE + m * 4)
          setup_r[m] <= wdata_i[`SU_W-1:0];
    end
  end

  // Program registers, sampled inputs and function outputs
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_user_r <= {NPTS{1'b0}};
      in_state_r <= {NPTS{1'b0}};
      in_prev_r <= {NPTS{1'b0}};
      irq_mask_r <= {`IRQ_W{1'b0}};
      irq_stat_r <= {`IRQ_W{1'b0}};
      rdata_o <= 32'h0000_0000;
      pin_o <= {NPTS{1'b0}};
      pin_oe_o <= {NPTS{1'b0}};
      src_type_o <= {NPTS{1'b0}};
      home_o <= 1'b0;
      plim_o <= 1'b0;
      nlim_o <= 1'b0;
      jogp_o <= 1'b0;
      jogn_o <= 1'b0;
      prog_start_o <= 1'b0;
      prog_addr_o <= 16'h0000;
      stop_decel_o <= 1'b0;
      prog_halt_o <= 1'b0;
      paused_o <= 1'b0;
      prog_reset_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      if (wr_i && addr_i == `OFF_OUT_USER)
        out_user_r <= wdata_i[NPTS-1:0];
      if (wr_i && addr_i == `OFF_IRQ_MASK)
        irq_mask_r <= wdata_i[`IRQ_W-1:0];
      in_state_r <= logic_nxt;
      in_prev_r <= in_state_r;
      // Read clears status, but a new event in that cycle wins
      if (rd_i && addr_i == `OFF_IRQ_STATUS)
        irq_stat_r <= ev_nxt;
      else
        irq_stat_r <= irq_stat_r | ev_nxt;
      irq_o <= |((irq_stat_r | ev_nxt) & irq_mask_r);
      rdata_o <= rd_i ? rd_nxt : 32'h0000_0000;
      pin_o <= drive_nxt;
      pin_oe_o <= oe_nxt;
      src_type_o <= src_nxt;
      home_o <= fn_lvl_nxt[0];
      plim_o <= fn_lvl_nxt[1];
      nlim_o <= fn_lvl_nxt[2];
      // Limits veto jogging toward the blocked side
      jogp_o <= fn_lvl_nxt[3] & ~fn_lvl_nxt[1];
      jogn_o <= fn_lvl_nxt[4] & ~fn_lvl_nxt[2];
      prog_start_o <= ev_nxt[`IRQ_GO];
      if (ev_nxt[`IRQ_GO])
        prog_addr_o <= `PROG_START_ADDR;
      stop_decel_o <= ev_nxt[`IRQ_STOP];
      prog_halt_o <= ev_nxt[`IRQ_STOP];
      prog_reset_o <= ev_nxt[`IRQ_RESET];
      // Stop and reset cancel a pause; pause edge toggles
      if (ev_nxt[`IRQ_STOP] || ev_nxt[`IRQ_RESET])
        paused_o <= 1'b0;
      else if (ev_nxt[`IRQ_PAUSE])
        paused_o <= ~paused_o;
    end
  end

endmodule // general_io_function_mapper

/* File: sim/io_field_model.sv */
`timescale 1ns/1ps
module io_field_model (
  input wire logic [7:0] drive_i, // Level driven by the block
  input wire logic [7:0] oe_i, // Block drives the point
  input wire logic [7:0] sw_i, // Switch and sensor levels
  output logic [7:0] level_o // Level on each point
);
  // A driven point sees its own drive level, the others see the switch
  assign level_o = (oe_i & drive_i) | (~oe_i & sw_i);
endmodule // io_field_model

/* File: sim/general_io_function_mapper_properties.sv */
`timescale 1ns/1ps
module io_map_props (
  input wire sys_clk_i, // Clock
  input wire nrst_i, // Reset, active low
  input wire rd_i, // Read strobe
  input wire [31:0] rdata_o, // Read data
  input wire [7:0] pin_oe_o, // Drive enables
  input wire prog_start_o, // Start pulse
  input wire [15:0] prog_addr_o, // Start address
  input wire stop_decel_o, // Stop pulse
  input wire prog_halt_o, // Halt pulse
  input wire prog_reset_o, // Reset pulse
  input wire paused_o, // Suspended
  input wire plim_o, // Positive limit
  input wire jogp_o // Jog positive
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  start_pulse_a: assert property (prog_start_o |=> !prog_start_o)
    else $error("start pulse too long");
  start_addr_a: assert property (prog_start_o |-> prog_addr_o == 16'h0001)
    else $error("start address wrong");
  stop_pulse_a: assert property (stop_decel_o |=> !stop_decel_o)
    else $error("stop pulse too long");
  reset_pulse_a: assert property (prog_reset_o |=> !prog_reset_o)
    else $error("reset pulse too long");
  reset_unpause_a: assert property (prog_reset_o |-> !paused_o)
    else $error("pause kept after reset");
  stop_unpause_a: assert property (stop_decel_o |-> !paused_o)
    else $error("pause kept after stop");
  halt_with_stop_a: assert property (prog_halt_o == stop_decel_o)
    else $error("halt and stop differ");
  jog_veto_a: assert property (plim_o |-> !jogp_o)
    else $error("jog into limit");
  read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside slot");
  idle_reset_a: assert property ($rose(nrst_i) |-> pin_oe_o == 8'h00)
    else $error("point driven after reset");
endmodule // io_map_props
bind general_io_function_mapper io_map_props u_props (.sys_clk_i, .nrst_i,
  .rd_i, .rdata_o, .pin_oe_o, .prog_start_o, .prog_addr_o, .stop_decel_o,
  .prog_halt_o,
  .prog_reset_o, .paused_o, .plim_o, .jogp_o);

/* File: sim/general_io_function_mapper_tb.sv */
`timescale 1ns/1ps
module general_io_function_mapper_tb;
  logic sys_clk_i, nrst_i, wr_i, rd_i, rd_d, e;
  logic moving_i, fault_i, stall_i, encoder_i, ramping_i, irq_o, prog_halt_o;
  logic home_o, plim_o, nlim_o, jogp_o, jogn_o, prog_start_o, stop_decel_o;
  logic paused_o, prog_reset_o;
  logic [7:0] addr_i, sw, lvl, pin_o, pin_oe_o, src_type_o;
  logic [15:0] prog_addr_o;
  logic [31:0] wdata_i, rdata_o, r, seed, expq[$];
  int num_errors, n_compared, c, k;
  int lv[5] = '{1, 2, 3, 7, 8};
  int pc[5] = '{6, 6, 4, 5, 9};
  int ev[5] = '{4, 0, 1, 2, 8};
  int ib[5] = '{2, 2, 0, 1, 3};
  general_io_function_mapper DUT (.sys_clk_i, .nrst_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .pin_i(lvl), .pin_o, .pin_oe_o, .src_type_o,
    .moving_i, .fault_i, .stall_i, .encoder_i, .ramping_i, .home_o, .plim_o,
    .nlim_o, .jogp_o, .jogn_o, .prog_start_o, .prog_addr_o, .stop_decel_o,
    .prog_halt_o, .paused_o, .prog_reset_o, .irq_o);
  io_field_model u_field (.drive_i(pin_o), .oe_i(pin_oe_o), .sw_i(sw),
    .level_o(lvl));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input [31:0] ex, input [31:0] got);
    n_compared++;
    if (got !== ex) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, input [31:0] ex);
    @(posedge sys_clk_i);
    expq.push_back(ex);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Clock, 20 ns period
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // Read data land one cycle after the strobe, oldest note first
  always @(posedge sys_clk_i) begin
    if (rd_d) chk("rdata", expq.pop_front(), rdata_o);
    rd_d <= rd_i;
  end
  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #400000;
    num_errors++;
    test_done();
  end
  initial begin
    {nrst_i, wr_i, rd_i, rd_d, addr_i, wdata_i, sw} = '0;
    {moving_i, fault_i, stall_i, encoder_i, ramping_i} = '0;
    num_errors = 0; n_compared = 0; seed = 85728;
    repeat (20) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    for (k = 0; k < 9; k++) rd(k == 8 ? 8'h40 : k * 4, 0);
    // User inputs, odd points active low
    for (k = 0; k < 8; k++) wr(k * 4, 8'h80 | (k % 2) << 5);
    repeat (4) begin
      r = xs(); sw <= r[7:0]; tick(3);
      rd(8'h24, r[7:0] ^ 8'hAA);
    end
    // User outputs, mixed polarity and drive type
    for (k = 0; k < 8; k++) wr(k * 4, 8'h90 | (k % 2) << 5 | (k & 2) << 5);
    r = xs(); wr(8'h20, r[7:0]); tick(2);
    chk("pin_o", r[7:0] ^ 8'hAA, pin_o);
    chk("pin_oe_o", 8'hFF, pin_oe_o);
    chk("src_type_o", 8'hCC, src_type_o);
    rd(8'h28, r[7:0]);
    rd(8'h24, 0);
    // Status driven outputs; all points sinking, odd points active low
    for (c = 1; c < 5; c++) begin
      for (k = 0; k < 8; k++) wr(k * 4, 8'h90 | c | (k % 2) << 5);
      repeat (4) begin
        r = xs();
        {ramping_i, encoder_i, stall_i, fault_i, moving_i} <= r[4:0];
        tick(3);
        e = c == 1 ? r[0] : c == 2 ? r[1] : c == 3 ? r[2] & r[3] : r[4] & r[0];
        chk("status out", {8{e}} ^ 8'hAA, pin_o);
      end
    end
    sw <= 8'h00;
    wr(8'h30, 8'h0F);
    for (k = 0; k < 5; k++) begin
      wr(0, 8'h80 | lv[k]); sw <= 8'h01; tick(3);
      chk("levels", 1 << k, {jogn_o, jogp_o, nlim_o, plim_o, home_o});
      rd(8'h34, 1 << k);
      sw <= 8'h00; tick(3);
    end
    for (k = 0; k < 5; k++) begin
      wr(0, 8'h80 | pc[k]); sw <= 8'h01; tick(2);
      chk("events", ev[k], {prog_reset_o, paused_o, stop_decel_o,
        prog_start_o});
      tick(1);
      chk("irq_o", 1, irq_o);
      rd(8'h2C, 1 << ib[k]);
      sw <= 8'h00; tick(2);
      chk("irq_o", 0, irq_o);
    end
    // Masked event still latches its status bit
    wr(8'h30, 0); wr(0, 8'h84); sw <= 8'h01; tick(4);
    chk("irq_o", 0, irq_o);
    rd(8'h2C, 1);
    tick(2);
    test_done();
  end
endmodule // general_io_function_mapper_tb
